// >>> gdm_pkg.sv
`default_nettype none
package gdm_pkg;
    // Clock and the one-second timebase of the update timeout counters
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned SECOND_NS       = 1000000000;
    localparam int unsigned TICK_CYCLES     = SECOND_NS / CLK_PERIOD_NS;

    // Register map, in 16-bit register addresses
    localparam int unsigned FLOW_BASE       = 'h0288;  // 648
    localparam int unsigned FLOW_WORDS      = 72;
    localparam int unsigned FLOW_FLOATS     = 36;
    localparam int unsigned BARO_BASE       = 'h0330;  // 816
    localparam int unsigned SHARED_BASE     = 'h0332;  // 818
    localparam int unsigned SHARED_WORDS    = 44;
    localparam int unsigned SHARED_FLOATS   = 22;
    localparam int unsigned SHARED_CNT_ADDR = 'h035e;  // 862
    localparam int unsigned DT_BASE         = 'h035f;  // 863
    localparam int unsigned DT_WORDS        = 5;
    localparam int unsigned STREAM_BASE     = 'h0366;  // 870
    localparam int unsigned STREAM_LAST     = 'h04e0;  // 1248
    localparam int unsigned STREAM_WORDS    = 54;
    localparam int unsigned STREAM_COUNT    = 8;
    localparam int unsigned STREAM_CNT_OFS  = 52;
    localparam int unsigned STREAM_FLOATS   = 26;

    // Storage layout: shared floats first, then one slice per stream
    localparam int unsigned COMP_DEPTH      = 256;
    localparam int unsigned COMP_AW         = 8;
    localparam int unsigned FLOW_DEPTH      = 64;
    localparam int unsigned FLOW_AW         = 6;
    localparam int unsigned STREAM_MEM_BASE = SHARED_FLOATS;
    localparam int unsigned SHARED_ITEM_OFS = 4;    // Shared area starts at the nitrogen item
    localparam int unsigned AREA_COUNT      = 9;    // Shared area plus eight streams

    // Date and time block fields and limits
    localparam int unsigned DT_SEC_OFS      = 0;
    localparam int unsigned DT_MIN_OFS      = 1;
    localparam int unsigned DT_HOUR_OFS     = 2;
    localparam int unsigned DT_DAY_OFS      = 3;
    localparam int unsigned DT_YEAR_OFS     = 4;
    localparam logic [7:0]  SEC_MAX         = 8'h3b;  // 59
    localparam logic [7:0]  HOUR_MAX        = 8'h17;  // 23
    localparam logic [7:0]  DAY_MAX         = 8'h1f;  // 31
    localparam logic [7:0]  WDAY_MAX        = 8'h07;
    localparam logic [7:0]  YEAR_MAX        = 8'h63;  // 99
    localparam logic [7:0]  MONTH_MAX       = 8'h0c;  // 12
    localparam logic [7:0]  FIELD_MIN       = 8'h01;
    localparam logic [15:0] DT_DAY_RESET    = 16'h0101;
    localparam logic [15:0] DT_YEAR_RESET   = 16'h0001;
    localparam logic [15:0] CNT_MAX         = 16'hffff;

    typedef enum logic [1:0] {SRC_KEYPAD, SRC_SHARED, SRC_STREAM} gdm_src_type;
    typedef enum logic [3:0] {
        AR_NONE, AR_FLOW, AR_BARO, AR_SHARED, AR_SCNT, AR_DT, AR_STREAM, AR_STCNT, AR_SPARE
    } gdm_area_type;

    // Decoded register address
    typedef struct packed {
        gdm_area_type area;
        logic [2:0]   stream;
        logic [7:0]   idx;
        logic         low;
        logic [2:0]   dt_ofs;
    } gdm_dec_type;

    // Current calendar as held in the date and time block
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } gdm_date_type;
endpackage
`default_nettype wire

// >>> gdm_word_mem.sv
`default_nettype none
module gdm_word_mem #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 256,
    parameter int unsigned AW    = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [AW-1:0]    i_raddr_a,
    output logic      [WIDTH-1:0] o_rdata_a,
    input  wire logic [AW-1:0]    i_raddr_b,
    output logic      [WIDTH-1:0] o_rdata_b
);
    logic [WIDTH-1:0] mem [DEPTH];

    // One write port, two registered read ports; no reset so it maps to RAM
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata_a <= mem[i_raddr_a];
        o_rdata_b <= mem[i_raddr_b];
    end
endmodule
`default_nettype wire

// >>> gdm_register_map.sv
`default_nettype none
module gdm_register_map #(
    parameter int unsigned TICK_LEN = gdm_pkg::TICK_CYCLES
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_resetn,
    input  wire logic [15:0]          i_reg_addr,
    input  wire logic                 i_reg_rd,
    input  wire logic                 i_reg_wr,
    input  wire logic [15:0]          i_reg_wdata,
    output logic      [15:0]          o_reg_rdata,
    output logic                      o_reg_ack,
    output logic                      o_reg_err,
    input  wire gdm_pkg::gdm_src_type i_comp_source,
    input  wire logic [15:0]          i_update_timeout,
    input  wire logic                 i_flow_wr,
    input  wire logic [5:0]           i_flow_idx,
    input  wire logic [31:0]          i_flow_value,
    input  wire logic                 i_calc_req,
    input  wire logic [2:0]           i_calc_stream,
    input  wire logic [4:0]           i_calc_item,
    output logic                      o_calc_valid,
    output logic      [31:0]          o_calc_value,
    output logic                      o_calc_fallback,
    output logic      [31:0]          o_baro_pressure,
    output gdm_pkg::gdm_date_type     o_date,
    output logic      [8:0]           o_timeout_alarm
);
    import gdm_pkg::*;

    gdm_dec_type dec;
    logic [15:0] off;
    logic [31:0] comp_rdata_a;
    logic [31:0] comp_rdata_b;
    logic [31:0] flow_rdata;
    logic        mem_we;
    logic [7:0]  calc_idx;
    logic        calc_fb;
    logic        pend_q, pend_d;
    logic [15:0] pend_addr_q, pend_addr_d;
    logic [15:0] pend_hi_q, pend_hi_d;
    logic [31:0] baro_q, baro_d;
    logic [15:0] dt_q [DT_WORDS];
    logic [15:0] dt_d [DT_WORDS];
    logic        s1_valid_q, s1_valid_d;
    logic        s1_err_q, s1_err_d;
    gdm_dec_type s1_dec_q, s1_dec_d;
    logic [15:0] s1_direct_q, s1_direct_d;
    logic [15:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic        err_q, err_d;
    logic [8:0]  clear_cnt;
    logic        pair_ok;
    logic        dt_ok;
    logic [15:0] cnt_q [AREA_COUNT];
    logic [15:0] cnt_d [AREA_COUNT];

    // Address decode of the host register port
    always_comb begin
        dec = '0;
        dec.area = AR_NONE;
        off = 16'h0000;
        if (i_reg_addr >= FLOW_BASE && i_reg_addr < FLOW_BASE + FLOW_WORDS) begin
            dec.area = AR_FLOW;
            off = 16'(i_reg_addr - FLOW_BASE);
        end else if (i_reg_addr >= BARO_BASE && i_reg_addr < SHARED_BASE) begin
            dec.area = AR_BARO;
            off = 16'(i_reg_addr - BARO_BASE);
        end else if (i_reg_addr >= SHARED_BASE && i_reg_addr < SHARED_BASE + SHARED_WORDS) begin
            dec.area = AR_SHARED;
            off = 16'(i_reg_addr - SHARED_BASE);
        end else if (i_reg_addr == SHARED_CNT_ADDR) begin
            dec.area = AR_SCNT;
        end else if (i_reg_addr >= DT_BASE && i_reg_addr < DT_BASE + DT_WORDS) begin
            dec.area = AR_DT;
            off = 16'(i_reg_addr - DT_BASE);
        end
        // One slice per stream, the last one starting at 1248
        for (int k = 0; k < STREAM_COUNT; k++) begin
            if (i_reg_addr >= STREAM_BASE + k * STREAM_WORDS &&
                i_reg_addr < STREAM_BASE + (k + 1) * STREAM_WORDS) begin
                off = 16'(i_reg_addr - (STREAM_BASE + k * STREAM_WORDS));
                dec.stream = 3'(k);
                dec.area = (off < STREAM_CNT_OFS) ? AR_STREAM :
                           (off == STREAM_CNT_OFS) ? AR_STCNT : AR_SPARE;
                dec.idx = 8'(STREAM_MEM_BASE + k * STREAM_FLOATS);
            end
        end
        dec.idx = dec.idx + off[8:1];
        dec.low = off[0];
        dec.dt_ofs = off[2:0];
    end

    // Second word of a float pairs with the held first word at the address below
    assign pair_ok = pend_q && (pend_addr_q == 16'(i_reg_addr - 16'h0001));

    // Range check of a date and time write
    always_comb begin
        unique case (int'(dec.dt_ofs))
            DT_SEC_OFS, DT_MIN_OFS: dt_ok = i_reg_wdata[7:0] <= SEC_MAX;
            DT_HOUR_OFS:            dt_ok = i_reg_wdata[7:0] <= HOUR_MAX;
            DT_DAY_OFS:             dt_ok = i_reg_wdata[15:8] >= FIELD_MIN && i_reg_wdata[15:8] <= DAY_MAX &&
                                            i_reg_wdata[7:0] >= FIELD_MIN && i_reg_wdata[7:0] <= WDAY_MAX;
            DT_YEAR_OFS:            dt_ok = i_reg_wdata[15:8] <= YEAR_MAX &&
                                            i_reg_wdata[7:0] >= FIELD_MIN && i_reg_wdata[7:0] <= MONTH_MAX;
            default:                dt_ok = 1'b0;
        endcase
    end

    // Host write path and request pipeline
    always_comb begin
        pend_d = pend_q;
        pend_addr_d = pend_addr_q;
        pend_hi_d = pend_hi_q;
        baro_d = baro_q;
        dt_d = dt_q;
        mem_we = 1'b0;
        clear_cnt = '0;
        s1_valid_d = i_reg_rd | i_reg_wr;
        s1_dec_d = dec;
        s1_err_d = (dec.area == AR_NONE) || (i_reg_rd && i_reg_wr);
        s1_direct_d = 16'h0000;
        unique case (dec.area)
            AR_BARO:  s1_direct_d = dec.low ? baro_q[15:0] : baro_q[31:16];
            AR_DT:    s1_direct_d = dt_q[dec.dt_ofs];
            default:  s1_direct_d = 16'h0000;
        endcase
        if (i_reg_wr && !i_reg_rd) begin
            pend_d = 1'b0;
            unique case (dec.area)
                AR_FLOW: s1_err_d = 1'b1;
                AR_BARO, AR_SHARED, AR_STREAM: begin
                    if (!dec.low) begin
                        pend_d = 1'b1;
                        pend_addr_d = i_reg_addr;
                        pend_hi_d = i_reg_wdata;
                    end else if (pair_ok) begin
                        if (dec.area == AR_BARO) begin
                            baro_d = {pend_hi_q, i_reg_wdata};
                        end else begin
                            mem_we = 1'b1;
                            clear_cnt[dec.area == AR_SHARED ? 0 : int'(dec.stream) + 1] = 1'b1;
                        end
                    end
                end
                AR_DT: begin
                    if (dt_ok) begin
                        dt_d[dec.dt_ofs] = i_reg_wdata;
                    end else begin
                        s1_err_d = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    // Answer stage: pick the register word once memories have answered
    always_comb begin
        ack_d = s1_valid_q;
        err_d = s1_valid_q & s1_err_q;
        unique case (s1_dec_q.area)
            AR_FLOW:              rdata_d = s1_dec_q.low ? flow_rdata[15:0] : flow_rdata[31:16];
            AR_SHARED, AR_STREAM: rdata_d = s1_dec_q.low ? comp_rdata_a[15:0] : comp_rdata_a[31:16];
            AR_SCNT:              rdata_d = cnt_q[0];
            AR_STCNT:             rdata_d = cnt_q[int'(s1_dec_q.stream) + 1];
            default:              rdata_d = s1_direct_q;
        endcase
        if (!s1_valid_q || s1_err_q) begin
            rdata_d = 16'h0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pend_q <= 1'b0;
            pend_addr_q <= 16'h0000;
            pend_hi_q <= 16'h0000;
            baro_q <= 32'h0000_0000;
            dt_q <= '{16'h0000, 16'h0000, 16'h0000, DT_DAY_RESET, DT_YEAR_RESET};
            s1_valid_q <= 1'b0;
            s1_err_q <= 1'b0;
            s1_dec_q <= '0;
            s1_direct_q <= 16'h0000;
            rdata_q <= 16'h0000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            pend_addr_q <= pend_addr_d;
            pend_hi_q <= pend_hi_d;
            baro_q <= baro_d;
            dt_q <= dt_d;
            s1_valid_q <= s1_valid_d;
            s1_err_q <= s1_err_d;
            s1_dec_q <= s1_dec_d;
            s1_direct_q <= s1_direct_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            err_q <= err_d;
        end
    end

    // Second timebase and per-area timeout counters
    logic [26:0] tick_cnt_q, tick_cnt_d;
    logic        tick;
    logic [8:0]  alarm_q, alarm_d;

    assign tick = (tick_cnt_q == 27'(TICK_LEN - 1));

    always_comb begin
        tick_cnt_d = tick ? 27'h0 : tick_cnt_q + 27'h1;
        for (int a = 0; a < AREA_COUNT; a++) begin
            cnt_d[a] = cnt_q[a];
            if (i_reg_wr && !i_reg_rd && ((a == 0 && dec.area == AR_SCNT) ||
                (a != 0 && dec.area == AR_STCNT && int'(dec.stream) + 1 == a))) begin
                cnt_d[a] = i_reg_wdata;
            end else if (clear_cnt[a]) begin
                cnt_d[a] = 16'h0000;
            end else if (tick && cnt_q[a] != CNT_MAX) begin
                cnt_d[a] = cnt_q[a] + 16'h0001;
            end
            alarm_d[a] = cnt_q[a] > i_update_timeout;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tick_cnt_q <= 27'h0;
            cnt_q <= '{default: 16'h0000};
            alarm_q <= 9'h000;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            cnt_q <= cnt_d;
            alarm_q <= alarm_d;
        end
    end

    // Calculation read port: source select, then alarm fallback
    logic c1_valid_q, c1_fb_q;
    logic calc_valid_q, calc_fb_q;
    logic [31:0] calc_value_q, calc_value_d;

    always_comb begin
        calc_idx = 8'(STREAM_MEM_BASE) + 8'(i_calc_stream) * 8'(STREAM_FLOATS) + 8'(i_calc_item);
        calc_fb = (i_calc_item >= 5'(STREAM_FLOATS)) || (i_comp_source == SRC_KEYPAD);
        if (i_comp_source == SRC_SHARED) begin
            calc_idx = 8'(i_calc_item) - 8'(SHARED_ITEM_OFS);
            calc_fb = calc_fb || (i_calc_item < 5'(SHARED_ITEM_OFS)) || alarm_q[0];
        end else if (i_comp_source == SRC_STREAM) begin
            calc_fb = calc_fb || alarm_q[int'(i_calc_stream) + 1];
        end
        calc_value_d = c1_fb_q ? 32'h0000_0000 : comp_rdata_b;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            c1_valid_q <= 1'b0;
            c1_fb_q <= 1'b0;
            calc_valid_q <= 1'b0;
            calc_fb_q <= 1'b0;
            calc_value_q <= 32'h0000_0000;
        end else begin
            c1_valid_q <= i_calc_req;
            c1_fb_q <= calc_fb;
            calc_valid_q <= c1_valid_q;
            calc_fb_q <= c1_valid_q & c1_fb_q;
            calc_value_q <= c1_valid_q ? calc_value_d : 32'h0000_0000;
        end
    end

    // Composition store, written only on a completed word pair
    gdm_word_mem #(.WIDTH(32), .DEPTH(COMP_DEPTH), .AW(COMP_AW)) u_comp_mem (
        .i_clk     (i_clk),
        .i_we      (mem_we),
        .i_waddr   (dec.idx),
        .i_wdata   ({pend_hi_q, i_reg_wdata}),
        .i_raddr_a (dec.idx),
        .o_rdata_a (comp_rdata_a),
        .i_raddr_b (calc_idx),
        .o_rdata_b (comp_rdata_b)
    );

    // Flowrates are loaded by the calculation side only
    gdm_word_mem #(.WIDTH(32), .DEPTH(FLOW_DEPTH), .AW(FLOW_AW)) u_flow_mem (
        .i_clk     (i_clk),
        .i_we      (i_flow_wr),
        .i_waddr   (i_flow_idx),
        .i_wdata   (i_flow_value),
        .i_raddr_a (dec.idx[5:0]),
        .o_rdata_a (flow_rdata),
        .i_raddr_b (6'h00),
        .o_rdata_b ()
    );

    assign o_reg_rdata = rdata_q;
    assign o_reg_ack = ack_q;
    assign o_reg_err = err_q;
    assign o_calc_valid = calc_valid_q;
    assign o_calc_value = calc_value_q;
    assign o_calc_fallback = calc_fb_q;
    assign o_baro_pressure = baro_q;
    assign o_timeout_alarm = alarm_q;
    assign o_date = '{year: dt_q[4][15:8], month: dt_q[4][7:0], day: dt_q[3][15:8], weekday: dt_q[3][7:0],
                      hour: dt_q[2][7:0], minute: dt_q[1][7:0], second: dt_q[0][7:0]};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Float update steps; host pulses may be spaced, so pairing goes by the held address
    sequence s_hi_write;
        i_reg_wr && !i_reg_rd && dec.area == AR_SHARED && !dec.low;
    endsequence
    sequence s_lo_write;
        i_reg_wr && !i_reg_rd && dec.area == AR_SHARED && dec.low && pair_ok;
    endsequence

    chk_flow_readonly: assert property (i_reg_wr && dec.area == AR_FLOW |-> ##2 o_reg_ack && o_reg_err)
        else $error("flowrate write not refused");
    chk_high_held: assert property (s_hi_write |=> pend_q)
        else $error("high word not held");
    chk_shared_clear: assert property (s_lo_write |=> cnt_q[0] == 16'h0000)
        else $error("shared counter not cleared on update");
    chk_lone_low: assert property (i_reg_wr && dec.low && !pend_q |-> !mem_we)
        else $error("unpaired low word committed");
    chk_alarm_raise: assert property (cnt_q[1] > i_update_timeout && $stable(i_update_timeout) |=> alarm_q[1])
        else $error("timeout alarm not raised");
    chk_cnt_saturate: assert property (tick && cnt_q[2] == CNT_MAX && !(i_reg_wr && dec.area == AR_STCNT) && !clear_cnt[2]
        |=> cnt_q[2] == CNT_MAX)
        else $error("timeout counter wrapped");
    chk_alarm_fallback: assert property (i_calc_req && i_comp_source == SRC_STREAM && alarm_q[int'(i_calc_stream) + 1]
        |-> ##2 o_calc_valid && o_calc_fallback)
        else $error("fallback missing under alarm");
    chk_shared_common: assert property (i_calc_req && i_comp_source == SRC_SHARED && i_calc_item >= 5'd4
        |-> calc_idx == 8'(i_calc_item) - 8'h04)
        else $error("shared read depends on stream");
    chk_day_range: assert property (i_reg_wr && !i_reg_rd && dec.area == AR_DT && int'(dec.dt_ofs) == DT_DAY_OFS &&
        i_reg_wdata[15:8] == 8'h00 |-> ##2 o_reg_err)
        else $error("day zero accepted");
    chk_month_range: assert property (i_reg_wr && !i_reg_rd && dec.area == AR_DT && int'(dec.dt_ofs) == DT_YEAR_OFS &&
        i_reg_wdata[7:0] > 8'h0c |-> ##2 o_reg_err)
        else $error("month above twelve accepted");
endmodule
`default_nettype wire

// >>> gdm_host_model.sv
`default_nettype none
// Host end of the register port: one request pulse, then the answer
module gdm_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_ack,
    input  wire logic        i_err,
    output logic      [15:0] o_addr,
    output logic             o_rd,
    output logic             o_wr,
    output logic      [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle with no request and junk on the released lines
    initial begin
        o_rd    = 1'b0;
        o_wr    = 1'b0;
        o_addr  = 16'hffff;
        o_wdata = 16'hffff;
    end

    // The port takes one-cycle pulses; the answer must come within four edges
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic e, output logic to);
        @(posedge i_clk);
        #1;
        o_wr    = w;
        o_rd    = ~w;
        o_addr  = a;
        o_wdata = d;
        @(posedge i_clk);
        #1;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = ~a;  // No stale value left after release
        o_wdata = ~d;
        to      = 1'b1;
        for (int n = 0; n < 4; n++) begin
            if (i_ack === 1'b1) begin
                q  = i_rdata;
                e  = i_err;
                to = 1'b0;
                break;
            end
            @(posedge i_clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import gdm_pkg::*;

    logic               clk;
    logic               resetn;
    logic               rd;
    logic               wr;
    logic        [15:0] addr;
    logic        [15:0] wdata;
    logic        [15:0] rdata;
    logic               ack;
    logic               err;
    gdm_src_type        src;
    logic        [15:0] upd_to;
    logic               fl_wr;
    logic        [5:0]  fl_idx;
    logic        [31:0] fl_val;
    logic               c_req;
    logic        [2:0]  c_st;
    logic        [4:0]  c_it;
    logic               c_vld;
    logic        [31:0] c_val;
    logic               c_fb;
    logic        [31:0] baro;
    gdm_date_type       date;
    logic        [8:0]  alarm;
    int                 err_count;
    int                 checks;

    // Short tick so the counters move within a few dozen cycles
    gdm_register_map #(.TICK_LEN(8)) u_gdm_register_map (.i_clk(clk), .i_resetn(resetn),
        .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_ack(ack), .o_reg_err(err), .i_comp_source(src), .i_update_timeout(upd_to),
        .i_flow_wr(fl_wr), .i_flow_idx(fl_idx), .i_flow_value(fl_val), .i_calc_req(c_req),
        .i_calc_stream(c_st), .i_calc_item(c_it), .o_calc_valid(c_vld), .o_calc_value(c_val),
        .o_calc_fallback(c_fb), .o_baro_pressure(baro), .o_date(date), .o_timeout_alarm(alarm));
    gdm_host_model u_gdm_host_model (.i_clk(clk), .i_rdata(rdata), .i_ack(ack), .i_err(err),
        .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

    always #5 clk = ~clk;

    task automatic chk(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            err_count++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask

    task automatic end_sim;
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // A lost answer ends the run at once
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic e);
        logic to;
        u_gdm_host_model.xfer(w, a, d, q, e, to);
        if (to) begin
            chk(1'b0, "no register answer");
            end_sim;
        end
    endtask

    task automatic wrc(input logic [15:0] a, input logic [15:0] d, input logic xe);
        logic [15:0] q;
        logic        e;
        acc(1'b1, a, d, q, e);
        chk(e === xe, "write status");
    endtask

    task automatic rdc(input logic [15:0] a, input logic [15:0] x);
        logic [15:0] q;
        logic        e;
        acc(1'b0, a, 16'h0000, q, e);
        chk(e === 1'b0 && q === x, "read data");
    endtask

    // High word first, low word commits the pair
    task automatic wf(input logic [15:0] a, input logic [31:0] v);
        wrc(a, v[31:16], 1'b0);
        wrc(a + 16'h0001, v[15:0], 1'b0);
    endtask

    task automatic calc(input logic [2:0] s, input logic [4:0] it, input logic [31:0] v, input logic fb);
        @(posedge clk);
        #1;
        c_req = 1'b1;
        c_st  = s;
        c_it  = it;
        @(posedge clk);
        #1;
        c_req = 1'b0;
        for (int n = 0; n < 4 && c_vld !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (c_vld !== 1'b1) begin
            chk(1'b0, "no calc answer");
            end_sim;
        end
        chk(c_vld === 1'b1 && c_val === v && c_fb === fb, "calc answer");
    endtask

    task automatic t_shared;
        wf(16'h0332, 32'h3f80_0001);
        rdc(16'h0332, 16'h3f80);
        rdc(16'h0333, 16'h0001);
        wrc(16'h0332, 16'h1234, 1'b0);
        rdc(16'h0332, 16'h3f80);
        wf(16'h035c, 32'h4100_0002);
        calc(3'h4, 5'h04, 32'h3f80_0001, 1'b0);
        calc(3'h7, 5'h19, 32'h4100_0002, 1'b0);
        calc(3'h0, 5'h02, 32'h0000_0000, 1'b1);
        wf(16'h0330, 32'hc2c8_0000);
        chk(baro === 32'hc2c8_0000, "barometric value");
    endtask

    task automatic t_stream;
        src = SRC_STREAM;
        wf(16'h0366, 32'h1111_2222);
        wf(16'h04e0, 32'h3333_4444);
        wf(16'h0396, 32'h5555_6666);
        calc(3'h0, 5'h00, 32'h1111_2222, 1'b0);
        calc(3'h7, 5'h00, 32'h3333_4444, 1'b0);
        calc(3'h0, 5'h18, 32'h5555_6666, 1'b0);
        wrc(16'h039b, 16'hffff, 1'b0);
        rdc(16'h039b, 16'h0000);
        src = SRC_KEYPAD;
        calc(3'h0, 5'h00, 32'h0000_0000, 1'b1);
    endtask

    task automatic t_flow_date;
        @(posedge clk);
        #1;
        fl_wr  = 1'b1;
        fl_idx = 6'h23;
        fl_val = 32'h4049_0fdb;
        @(posedge clk);
        #1;
        fl_wr = 1'b0;
        rdc(16'h02ce, 16'h4049);
        rdc(16'h02cf, 16'h0fdb);
        wrc(16'h02ce, 16'h0000, 1'b1);
        wrc(16'h0000, 16'h0000, 1'b1);
        wrc(16'h0362, 16'h1f07, 1'b0);
        wrc(16'h0363, 16'h630c, 1'b0);
        rdc(16'h0362, 16'h1f07);
        wrc(16'h0362, 16'h2001, 1'b1);
        wrc(16'h0362, 16'h1f00, 1'b1);
        wrc(16'h0363, 16'h640c, 1'b1);
        wrc(16'h0363, 16'h630d, 1'b1);
        wrc(16'h0362, 16'h0003, 1'b1);
        wrc(16'h0361, 16'h0017, 1'b0);
        wrc(16'h0360, 16'h3b3b, 1'b0);
        wrc(16'h035f, 16'h003c, 1'b1);
        chk(date.hour === 8'h17 && date.minute === 8'h3b && date.second === 8'h00, "time fields");
        chk(date.day === 8'h1f && date.weekday === 8'h07, "day fields");
        chk(date.year === 8'h63 && date.month === 8'h0c, "year fields");
    endtask

    // Saturation first, then alarm, fallback and clear per area
    task automatic t_timeout;
        wrc(16'h035e, 16'hfff0, 1'b0);
        wrc(16'h03d0, 16'hfff0, 1'b0);
        repeat (200) @(posedge clk);
        rdc(16'h035e, 16'hffff);
        rdc(16'h03d0, 16'hffff);
        upd_to = 16'h0002;
        wrc(16'h035e, 16'h0000, 1'b0);
        repeat (12) @(posedge clk);
        #1;
        chk(alarm[0] === 1'b0, "early alarm");
        for (int n = 0; n < 40 && alarm[0] !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(alarm === 9'h1ff, "alarms raised");
        src = SRC_SHARED;
        calc(3'h2, 5'h04, 32'h0000_0000, 1'b1);
        wf(16'h0332, 32'h3f80_0003);
        chk(alarm[0] === 1'b0, "shared alarm kept");
        calc(3'h2, 5'h04, 32'h3f80_0003, 1'b0);
        wf(16'h04e0, 32'h0000_0000);
        chk(alarm[8] === 1'b0 && alarm[7] === 1'b1, "stream alarms");
        src = SRC_STREAM;
        calc(3'h6, 5'h00, 32'h0000_0000, 1'b1);
        calc(3'h7, 5'h00, 32'h0000_0000, 1'b0);
        upd_to = 16'hffff;
    endtask

    initial begin
        clk       = 1'b0;
        resetn    = 1'b0;
        src       = SRC_SHARED;
        upd_to    = 16'hffff;
        fl_wr     = 1'b0;
        fl_idx    = 6'h00;
        fl_val    = 32'h0000_0000;
        c_req     = 1'b0;
        c_st      = 3'h0;
        c_it      = 5'h00;
        err_count = 0;
        checks    = 0;
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk(date.day === 8'h01 && date.weekday === 8'h01 && date.month === 8'h01, "date reset");
        t_shared;
        t_stream;
        t_flow_date;
        t_timeout;
        end_sim;
    end
endmodule
`default_nettype wire
